/* File: tbs_pkg.sv */
package tbs_pkg;

    // structure of the switch
    localparam int NUM_GRP = 6;
    localparam int SRC_PER_GRP = 4;
    localparam int NUM_SRC = 24;

    // reporting interval
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_MS = 5;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

    // simulator bit clock half period in ref_clk cycles (1 MHz stream)
    localparam int SIM_HALF_CYCLES = 20;

    // register offsets: group g occupies GRP_STRIDE*g + OFS_*
    localparam logic [7:0] GRP_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FRMLEN = 8'h04;
    localparam logic [7:0] OFS_PATTERN = 8'h08;
    localparam logic [7:0] OFS_AUX = 8'h0C;
    localparam logic [7:0] ADR_SELSTAT = 8'h60;
    localparam logic [7:0] ADR_LOCKNOW = 8'h64;
    localparam logic [7:0] ADR_SNAP = 8'h68;
    localparam logic [7:0] ADR_SCOUNT = 8'h6C;
    localparam logic [7:0] ADR_SIMLEN = 8'h70;
    localparam logic [7:0] ADR_SIMPAT = 8'h74;
    localparam logic [7:0] ADR_LOCKCNT0 = 8'h80;

    // group control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MASTER_LSB = 2;
    localparam int CTRL_FORCE_LSB = 5;
    localparam int CTRL_DEF_LSB = 7;
    localparam int CTRL_APPLY_BIT = 9;
    localparam int CTRL_POL_LSB = 10;
    localparam int CTRL_RANK_LSB = 12;
    localparam int CTRL_PLEN_LSB = 20;
    localparam int AUX_LOCK_LSB = 0;
    localparam int AUX_UNLK_LSB = 3;
    localparam int AUX_TEST_BIT = 6;
    localparam int AUX_CASC_BIT = 7;
    localparam int AUX_SIMMASK_LSB = 8;

    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h01FE_4000;
    localparam logic [15:0] FRMLEN_RST = 16'h00FF;
    localparam logic [31:0] PATTERN_RST = 32'hFE6B_2840;
    localparam logic [31:0] AUX_RST = 32'h0000_0F1B;
    localparam logic [15:0] MIN_FRMLEN_M1 = 16'h000F;
    localparam logic [15:0] SIMLEN_RST = 16'h00FF;
    localparam logic [31:0] SIMPAT_RST = 32'hFE6B_2840;

    typedef enum logic [1:0] {MODE_AUTO, MODE_FORCED, MODE_SLAVE} tbs_mode_t;
    typedef enum logic [1:0] {POL_NORMAL, POL_INVERT, POL_AUTO} tbs_pol_t;
    typedef enum logic [1:0] {FS_SEARCH, FS_CHECK, FS_LOCK} tbs_fstate_t;

endpackage : tbs_pkg

/* File: tbs_best_source_choice.sv */
// Notes on behaviour
// - each group takes one to four sources and drives one output
// - every source holds a priority rank used by auto mode decisions
// - auto mode routes the best-ranked locked source to the group output
// - on lock loss look first for a higher-ranked locked source
// - failing that, take a lower-ranked locked source of the same group
// - with no other locked source the routing stays as it is
// - forced mode holds the chosen routing whatever the lock states do
// - a slave group copies the source position chosen by its master
// - a group output can feed a later group input for larger groups
// - a default source may be chosen, but only while it is locked
// - each group has its own rate, sync pattern and frame length
// - frame length is any value from 16 to 65536 bits
// - sync pattern is expected at a fixed interval only
// - lock detection handles normal, inverted and auto polarity
// - streams are NRZ-L data with clock, 1 bps to 35 Mbps
// - routed bits pass unaltered to the output
// - lock status of all sources is sampled and reported every 5 ms
// - per source cumulative locked samples kept beside live status
// - one discrete lock output for each of the 24 frame-sync units
// - test mode feeds simulated telemetry into a group's inputs
`timescale 1ns/1ps
module tbs_best_source_choice #(
    parameter int SAMPLE_CYCLES = tbs_pkg::SAMPLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [tbs_pkg::NUM_SRC-1:0] srcData,
    input wire logic [tbs_pkg::NUM_SRC-1:0] srcClk,
    output logic [tbs_pkg::NUM_GRP-1:0] grpData,
    output logic [tbs_pkg::NUM_GRP-1:0] grpClk,
    output logic [tbs_pkg::NUM_SRC-1:0] lockOut,
    output logic sampleStrobe,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);

    localparam int NG = tbs_pkg::NUM_GRP;
    localparam int NS = tbs_pkg::NUM_SRC;
    localparam int SPG = tbs_pkg::SRC_PER_GRP;
    localparam int SCW = $clog2(SAMPLE_CYCLES);

    // configuration registers
    logic [31:0] ctrl_r [NG];
    logic [15:0] frmLen_r [NG];
    logic [31:0] pattern_r [NG];
    logic [31:0] aux_r [NG];
    logic [15:0] simLen_r;
    logic [31:0] simPat_r;
    logic [NG-1:0] applyDef;

    // status
    logic [NS-1:0] locked;
    logic [1:0] sel_r [NG];
    logic [NG-1:0] defHold_r;
    logic [NG-1:0] outData_r;
    logic [NG-1:0] outClk_r;
    logic [NS-1:0] snap_r;
    logic [31:0] sampleCnt_r;
    logic [31:0] lockCnt_r [NS];
    logic [SCW-1:0] tickCnt_r;
    logic tick;
    logic [31:0] rdNxt;

    // effective (muxed) per-source stream
    logic [NS-1:0] effDat;
    logic [NS-1:0] effClk;
    logic [NS-1:0] effClkPrev_r;

    // simulator
    logic simClk_r;
    logic simDat_r;
    logic [5:0] simDiv_r;
    logic [15:0] simPos_r;

    // register writes; frame length below 16 bits is raised to 16
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int g = 0; g < NG; g++)
            begin
                ctrl_r[g] <= tbs_pkg::CTRL_RST;
                frmLen_r[g] <= tbs_pkg::FRMLEN_RST;
                pattern_r[g] <= tbs_pkg::PATTERN_RST;
                aux_r[g] <= tbs_pkg::AUX_RST;
            end
            simLen_r <= tbs_pkg::SIMLEN_RST;
            simPat_r <= tbs_pkg::SIMPAT_RST;
        end
        else if (regWr)
        begin
            for (int g = 0; g < NG; g++)
            begin
                if (regAddr == 8'(g * 16) + tbs_pkg::OFS_CTRL)
                begin
                    ctrl_r[g] <= regWdata
                        & ~(32'h1 << tbs_pkg::CTRL_APPLY_BIT);
                end
                if (regAddr == 8'(g * 16) + tbs_pkg::OFS_FRMLEN)
                begin
                    frmLen_r[g] <= (regWdata[15:0] < tbs_pkg::MIN_FRMLEN_M1)
                        ? tbs_pkg::MIN_FRMLEN_M1 : regWdata[15:0];
                end
                if (regAddr == 8'(g * 16) + tbs_pkg::OFS_PATTERN)
                begin
                    pattern_r[g] <= regWdata;
                end
                if (regAddr == 8'(g * 16) + tbs_pkg::OFS_AUX)
                begin
                    aux_r[g] <= regWdata;
                end
            end
            if (regAddr == tbs_pkg::ADR_SIMLEN)
            begin
                simLen_r <= (regWdata[15:0] < tbs_pkg::MIN_FRMLEN_M1)
                    ? tbs_pkg::MIN_FRMLEN_M1 : regWdata[15:0];
            end
            if (regAddr == tbs_pkg::ADR_SIMPAT)
            begin
                simPat_r <= regWdata;
            end
        end
    end

    // one-cycle request to adopt the default source
    always_comb
    begin
        for (int g = 0; g < NG; g++)
        begin
            applyDef[g] = regWr
                && (regAddr == 8'(g * 16) + tbs_pkg::OFS_CTRL)
                && regWdata[tbs_pkg::CTRL_APPLY_BIT];
        end
    end

    // simulated stream: pattern msb first, then zeros to frame end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            simDiv_r <= 6'h00;
            simClk_r <= 1'b0;
            simDat_r <= 1'b0;
            simPos_r <= 16'h0000;
        end
        else if (simDiv_r == 6'(tbs_pkg::SIM_HALF_CYCLES - 1))
        begin
            simDiv_r <= 6'h00;
            simClk_r <= ~simClk_r;
            // data changes on the falling edge, stable for the rising one
            if (simClk_r)
            begin
                simDat_r <= (simPos_r < 16'h0020)
                    ? simPat_r[5'(16'h001F - simPos_r)] : 1'b0;
                simPos_r <= (simPos_r >= simLen_r)
                    ? 16'h0000 : simPos_r + 16'h0001;
            end
        end
        else
        begin
            simDiv_r <= simDiv_r + 6'h01;
        end
    end

    // per source: pin synchroniser, input mux and frame-sync unit
    for (genvar i = 0; i < NS; i++)
    begin : g_src
        localparam int G = i / SPG;
        localparam int S = i % SPG;
        logic [2:0] datSync_r;
        logic [2:0] clkSync_r;
        logic datStable_r;
        logic clkStable_r;
        logic edgeSeen;
        logic [31:0] shift_r;
        logic [31:0] shiftNxt;
        logic [31:0] mask;
        logic [15:0] bitCnt_r;
        logic [2:0] hits_r;
        logic [2:0] misses_r;
        logic [2:0] lockNeed;
        logic [2:0] unlockNeed;
        logic matchN;
        logic matchI;
        logic match;
        logic atFrame;
        tbs_pkg::tbs_pol_t pol;
        tbs_pkg::tbs_fstate_t fs_r;

        // three flops; a change counts once the last two agree
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                datSync_r <= 3'h0;
                clkSync_r <= 3'h0;
                datStable_r <= 1'b0;
                clkStable_r <= 1'b0;
            end
            else
            begin
                datSync_r <= {datSync_r[1:0], srcData[i]};
                clkSync_r <= {clkSync_r[1:0], srcClk[i]};
                if (datSync_r[1] == datSync_r[2])
                begin
                    datStable_r <= datSync_r[2];
                end
                if (clkSync_r[1] == clkSync_r[2])
                begin
                    clkStable_r <= clkSync_r[2];
                end
            end
        end

        // test feed, cascade from previous group, or the pin
        always_comb
        begin
            if (aux_r[G][tbs_pkg::AUX_TEST_BIT])
            begin
                effDat[i] = aux_r[G][tbs_pkg::AUX_SIMMASK_LSB + S]
                    & simDat_r;
                effClk[i] = aux_r[G][tbs_pkg::AUX_SIMMASK_LSB + S]
                    & simClk_r;
            end
            else if ((S == SPG - 1) && (G > 0)
                && aux_r[G][tbs_pkg::AUX_CASC_BIT])
            begin
                effDat[i] = outData_r[(G > 0) ? G - 1 : 0];
                effClk[i] = outClk_r[(G > 0) ? G - 1 : 0];
            end
            else
            begin
                effDat[i] = datStable_r;
                effClk[i] = clkStable_r;
            end
        end

        // NRZ-L bit taken on the rising edge of its own clock
        assign edgeSeen = effClk[i] & ~effClkPrev_r[i];
        assign shiftNxt = {shift_r[30:0], effDat[i]};
        assign mask = 32'((33'h1 << (6'(ctrl_r[G][
            tbs_pkg::CTRL_PLEN_LSB +: 5]) + 6'h01)) - 33'h1);
        assign pol = tbs_pkg::tbs_pol_t'(ctrl_r[G][tbs_pkg::CTRL_POL_LSB +: 2]);
        assign matchN = ((shiftNxt ^ pattern_r[G]) & mask) == 32'h0;
        assign matchI = ((~shiftNxt ^ pattern_r[G]) & mask) == 32'h0;

        // polarity: normal, inverted or accept either
        always_comb
        begin
            unique case (pol)
                tbs_pkg::POL_NORMAL: match = matchN;
                tbs_pkg::POL_INVERT: match = matchI;
                tbs_pkg::POL_AUTO: match = matchN | matchI;
                default: match = matchN;
            endcase
        end

        // a count of zero is taken as one
        assign lockNeed = (aux_r[G][tbs_pkg::AUX_LOCK_LSB +: 3] == 3'h0)
            ? 3'h1 : aux_r[G][tbs_pkg::AUX_LOCK_LSB +: 3];
        assign unlockNeed = (aux_r[G][tbs_pkg::AUX_UNLK_LSB +: 3] == 3'h0)
            ? 3'h1 : aux_r[G][tbs_pkg::AUX_UNLK_LSB +: 3];
        // next sync expected one fixed frame length later
        assign atFrame = (bitCnt_r == frmLen_r[G]);

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                effClkPrev_r[i] <= 1'b0;
            end
            else
            begin
                effClkPrev_r[i] <= effClk[i];
            end
        end

        // frame-sync state: search, check, lock
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                shift_r <= 32'h0;
                bitCnt_r <= 16'h0;
                hits_r <= 3'h0;
                misses_r <= 3'h0;
                fs_r <= tbs_pkg::FS_SEARCH;
            end
            else if (edgeSeen)
            begin
                shift_r <= shiftNxt;
                bitCnt_r <= atFrame ? 16'h0 : bitCnt_r + 16'h1;
                unique case (fs_r)
                    tbs_pkg::FS_SEARCH:
                    begin
                        bitCnt_r <= 16'h0;
                        hits_r <= 3'h1;
                        misses_r <= 3'h0;
                        if (match)
                        begin
                            fs_r <= (lockNeed == 3'h1)
                                ? tbs_pkg::FS_LOCK : tbs_pkg::FS_CHECK;
                        end
                    end
                    tbs_pkg::FS_CHECK:
                    begin
                        if (atFrame && match)
                        begin
                            hits_r <= hits_r + 3'h1;
                            if (hits_r + 3'h1 >= lockNeed)
                            begin
                                fs_r <= tbs_pkg::FS_LOCK;
                            end
                        end
                        else if (atFrame)
                        begin
                            fs_r <= tbs_pkg::FS_SEARCH;
                        end
                    end
                    tbs_pkg::FS_LOCK:
                    begin
                        if (atFrame && match)
                        begin
                            misses_r <= 3'h0;
                        end
                        else if (atFrame)
                        begin
                            misses_r <= misses_r + 3'h1;
                            if (misses_r + 3'h1 >= unlockNeed)
                            begin
                                fs_r <= tbs_pkg::FS_SEARCH;
                            end
                        end
                    end
                    default: fs_r <= tbs_pkg::FS_SEARCH;
                endcase
            end
        end

        assign locked[i] = (fs_r == tbs_pkg::FS_LOCK);
    end

    // per group: choice of source and routing of data with clock
    for (genvar g = 0; g < NG; g++)
    begin : g_grp
        logic [3:0] grpLock;
        logic [1:0] best;
        logic found;
        logic [1:0] defSrc;
        logic [1:0] forceSrc;
        logic [2:0] master;
        tbs_pkg::tbs_mode_t mode;

        assign grpLock = locked[g * SPG +: SPG];
        assign defSrc = ctrl_r[g][tbs_pkg::CTRL_DEF_LSB +: 2];
        assign forceSrc = ctrl_r[g][tbs_pkg::CTRL_FORCE_LSB +: 2];
        assign master = ctrl_r[g][tbs_pkg::CTRL_MASTER_LSB +: 3];
        assign mode = tbs_pkg::tbs_mode_t'(ctrl_r[g][
            tbs_pkg::CTRL_MODE_LSB +: 2]);

        // lowest rank value wins; ties go to the lower slot
        always_comb
        begin
            logic [1:0] bestRank;
            bestRank = 2'h3;
            best = sel_r[g];
            found = 1'b0;
            for (int s = 0; s < SPG; s++)
            begin
                if (grpLock[s] && (!found || ctrl_r[g][
                    tbs_pkg::CTRL_RANK_LSB + 2 * s +: 2] < bestRank))
                begin
                    found = 1'b1;
                    best = 2'(s);
                    bestRank = ctrl_r[g][tbs_pkg::CTRL_RANK_LSB + 2 * s +: 2];
                end
            end
        end

        // default is held only while it stays locked
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                defHold_r[g] <= 1'b0;
            end
            else if (applyDef[g])
            begin
                defHold_r[g] <= grpLock[regWdata[tbs_pkg::CTRL_DEF_LSB +: 2]];
            end
            else if (!grpLock[defSrc] || mode != tbs_pkg::MODE_AUTO)
            begin
                defHold_r[g] <= 1'b0;
            end
        end

        // selection by mode; the best locked source is the higher-ranked
        // one when present, a lower one otherwise
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sel_r[g] <= 2'h0;
            end
            else
            begin
                unique case (mode)
                    tbs_pkg::MODE_FORCED:
                    begin
                        sel_r[g] <= forceSrc;
                    end
                    tbs_pkg::MODE_SLAVE:
                    begin
                        // a bad master index leaves the routing alone
                        if (master < 3'(NG) && master != 3'(g))
                        begin
                            sel_r[g] <= sel_r[master];
                        end
                    end
                    default:
                    begin
                        if (defHold_r[g] && grpLock[defSrc])
                        begin
                            sel_r[g] <= defSrc;
                        end
                        else if (found)
                        begin
                            sel_r[g] <= best;
                        end
                        // nothing locked: keep present routing
                    end
                endcase
            end
        end

        // bits copied as they are, data and clock from one source
        // one cycle of ref_clk delay keeps the pair aligned
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                outData_r[g] <= 1'b0;
                outClk_r[g] <= 1'b0;
            end
            else
            begin
                outData_r[g] <= effDat[g * SPG + int'(sel_r[g])];
                outClk_r[g] <= effClk[g * SPG + int'(sel_r[g])];
            end
        end
    end

    assign grpData = outData_r;
    assign grpClk = outClk_r;

    // 5 ms sample tick, snapshot and cumulative counts
    assign tick = (tickCnt_r == SCW'(SAMPLE_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tickCnt_r <= '0;
            sampleStrobe <= 1'b0;
            snap_r <= '0;
            sampleCnt_r <= 32'h0;
            for (int i = 0; i < NS; i++)
            begin
                lockCnt_r[i] <= 32'h0;
            end
        end
        else
        begin
            tickCnt_r <= tick ? '0 : tickCnt_r + SCW'(1);
            sampleStrobe <= tick;
            if (tick)
            begin
                snap_r <= locked;
                sampleCnt_r <= sampleCnt_r + 32'h1;
                for (int i = 0; i < NS; i++)
                begin
                    // ratio to sampleCnt gives the lock percentage
                    lockCnt_r[i] <= lockCnt_r[i] + {31'h0, locked[i]};
                end
            end
        end
    end

    // discrete lock outputs, one per frame-sync unit
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lockOut <= '0;
        end
        else
        begin
            lockOut <= locked;
        end
    end

    // read decode; unmapped addresses read zero
    always_comb
    begin
        rdNxt = 32'h0;
        for (int g = 0; g < NG; g++)
        begin
            if (regAddr == 8'(g * 16) + tbs_pkg::OFS_CTRL)
            begin
                rdNxt = ctrl_r[g];
            end
            if (regAddr == 8'(g * 16) + tbs_pkg::OFS_FRMLEN)
            begin
                rdNxt = {16'h0, frmLen_r[g]};
            end
            if (regAddr == 8'(g * 16) + tbs_pkg::OFS_PATTERN)
            begin
                rdNxt = pattern_r[g];
            end
            if (regAddr == 8'(g * 16) + tbs_pkg::OFS_AUX)
            begin
                rdNxt = aux_r[g];
            end
        end
        if (regAddr == tbs_pkg::ADR_SELSTAT)
        begin
            for (int g = 0; g < NG; g++)
            begin
                rdNxt[2 * g +: 2] = sel_r[g];
                rdNxt[16 + g] = defHold_r[g];
            end
        end
        if (regAddr == tbs_pkg::ADR_LOCKNOW)
        begin
            rdNxt = {8'h0, locked};
        end
        if (regAddr == tbs_pkg::ADR_SNAP)
        begin
            rdNxt = {8'h0, snap_r};
        end
        if (regAddr == tbs_pkg::ADR_SCOUNT)
        begin
            rdNxt = sampleCnt_r;
        end
        if (regAddr == tbs_pkg::ADR_SIMLEN)
        begin
            rdNxt = {16'h0, simLen_r};
        end
        if (regAddr == tbs_pkg::ADR_SIMPAT)
        begin
            rdNxt = simPat_r;
        end
        if (regAddr >= tbs_pkg::ADR_LOCKCNT0
            && regAddr[6:2] < 5'(NS))
        begin
            rdNxt = lockCnt_r[regAddr[6:2]];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdata <= 32'h0;
        end
        else
        begin
            regRdata <= regRd ? rdNxt : 32'h0;
        end
    end

endmodule : tbs_best_source_choice

/* File: tbs_check_monitor.sv */
`timescale 1ns/1ps
module tbs_check_monitor #(
    parameter int SAMPLE_CYCLES = 200
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [23:0] srcData,
    input wire logic [23:0] srcClk,
    input wire logic [5:0] grpData,
    input wire logic [5:0] grpClk,
    input wire logic [23:0] lockOut,
    input wire logic sampleStrobe,
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic [31:0] regRdata
);
    // input latency is 5 cycles, so depths 4 to 6 bracket it
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
        else $error("strobe too long");
    a_strobe_period: assert property (
        sampleStrobe |-> ##SAMPLE_CYCLES sampleStrobe) else $error("period");
    a_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
    a_lock_read: assert property (
        regRd && regAddr == 8'h64 ##1 $stable(lockOut)
        |-> regRdata == {8'h00, lockOut}) else $error("lock read");
    a_clk_pair: assert property ($rose(grpClk[0]) |->
        |{$past(srcClk[3:0], 4), $past(srcClk[3:0], 5), $past(srcClk[3:0], 6)})
        else $error("clock not from group");
    a_data_one: assert property (
        &{$past(srcData[3:0], 4), $past(srcData[3:0], 5),
        $past(srcData[3:0], 6)} |-> grpData[0]) else $error("data one");
    a_data_zero: assert property (
        !(|{$past(srcData[7:4], 4), $past(srcData[7:4], 5),
        $past(srcData[7:4], 6)}) |-> !grpData[1]) else $error("data zero");
    a_unmapped_zero: assert property (
        regRd && regAddr == 8'h78 |=> regRdata == 32'h0) else $error("unmapped");
endmodule : tbs_check_monitor

/* File: tbs_src_model.sv */
`timescale 1ns/1ps
module tbs_src_model (
    input wire logic ref_clk,
    input wire logic [23:0] en,
    output logic [23:0] srcData,
    output logic [23:0] srcClk
);
    int ph = 0;
    int bitIdx = 0;
    logic bitVal;
    // 200 ns bit period, data moves with the falling clock edge
    always @(posedge ref_clk)
    begin
        ph <= (ph + 1) % 8;
        if (ph == 7)
            bitIdx <= (bitIdx + 1) % 256;
    end
    // sync word msb first, then zero fill to the frame end
    assign bitVal = bitIdx < 32 ? tbs_pkg::PATTERN_RST[31 - bitIdx] : 1'b0;
    // a quiet source keeps clocking but sends zeros: a stopped clock would
    // leave the frame-sync unit waiting for an edge and never miss a sync
    assign srcClk = {24{ph >= 4}};
    assign srcData = en & {24{bitVal}};
endmodule : tbs_src_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, sampleStrobe, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [23:0] srcData, srcClk, lockOut, en = 24'h0;
    logic [5:0] grpData, grpClk;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, d, rf = 32'h01F0_0000;
    int errors = 0, comparisons = 0, rk[6][4], sel[6];
    tbs_src_model tbs_src_model_i (.ref_clk, .en, .srcData, .srcClk);
    tbs_best_source_choice #(.SAMPLE_CYCLES(200)) tbs_best_source_choice_i (
        .ref_clk, .rst_n, .srcData, .srcClk, .grpData, .grpClk, .lockOut,
        .sampleStrobe, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= w;
        regRd <= !w;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // model: best rank among locked slots, ties to the lower slot, else hold
    function automatic int best(input int g);
        int b = sel[g];
        int r = 4;
        for (int s = 0; s < 4; s++)
            if (en[4*g+s] && rk[g][s] < r)
            begin
                b = s;
                r = rk[g][s];
            end
        return b;
    endfunction : best
    task automatic settle();
        @(negedge ref_clk);
        for (int i = 0; i < 12000 && lockOut !== en; i++)
            @(negedge ref_clk);
        chk(32'(lockOut), 32'(en));
        repeat (8) @(posedge ref_clk);
        bus(1'b0, 8'h64, 32'h0);
        chk(d, {8'h00, en});
        bus(1'b0, 8'h60, 32'h0);
        for (int g = 0; g < 3; g++)
        begin
            sel[g] = best(g);
            chk(32'(d[2*g+:2]), 32'(sel[g]));
        end
        chk(32'(d[7:6]), 32'h2);
        chk(32'(d[9:8]), 32'(sel[1]));
    endtask : settle
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h9053D53D));
        foreach (rk[g, s])
            rk[g][s] = s;
        sel = '{default: 0};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(d, tbs_pkg::CTRL_RST);
        bus(1'b0, 8'h78, 32'h0);
        chk(d, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk(d, 32'(tbs_pkg::MIN_FRMLEN_M1));
        bus(1'b1, 8'h04, 32'(tbs_pkg::FRMLEN_RST));
        $display("register test done");
        for (int s = 0; s < 4; s++)
        begin
            rk[1][s] = $urandom % 4;
            rf = rf | (32'(rk[1][s]) << (2 * s + 12));
        end
        bus(1'b1, 8'h10, rf);
        bus(1'b1, 8'h30, 32'h01FE_4041);
        bus(1'b1, 8'h40, 32'h01FE_4006);
        @(posedge ref_clk);
        en <= 24'hFF_FFFF;
        settle();
        $display("lock and select test done");
        @(posedge ref_clk);
        en[4+sel[1]] <= 1'b0;
        en[11:8] <= 4'h0;
        en[14] <= 1'b0;
        settle();
        $display("lock loss test done");
        // default slot 2: taken in locked group 0, refused in dead group 2
        bus(1'b1, 8'h00, 32'h01FE_4300);
        bus(1'b1, 8'h20, 32'h01FE_4300);
        bus(1'b0, 8'h00, 32'h0);
        chk(d, 32'h01FE_4100);
        bus(1'b0, 8'h60, 32'h0);
        chk(32'(d[1:0]), 32'h2);
        chk(32'({d[18], d[16], d[5:4]}), 32'h4);
        $display("default source test done");
        wrap_up();
    end
endmodule : tb_top
bind tbs_best_source_choice tbs_check_monitor #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)) tbs_check_monitor_i (.ref_clk, .rst_n,
    .srcData, .srcClk, .grpData, .grpClk, .lockOut, .sampleStrobe, .regAddr,
    .regRd, .regRdata);
